/* rtl/rpf_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module rpf_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rx_address,
  input wire logic [1:0] rx_addr_check_mode,
  output logic rx_address_match,
  output logic legacy_conflict,
  output logic [31:0] base_frequency_word_rx_word,
  output logic [31:0] base_frequency_word_tx_word,
  input wire logic [7:0] channel_spacing,
  output logic [5:0] decim_ratio,
  output logic [12:0] symbol_rate_word,
  input wire logic legacy_compat_enable,
  output rpf_pkg::rpf_pkt_cfg_t pkt_cfg,
  output rpf_pkg::rpf_base_frequency_word_cfg_t base_frequency_word_cfg
);
  logic [7:0] pkt_ctrl_q;
  logic [7:0] pkt_ctrl_d;
  logic [7:0] dev_addr_q;
  logic [7:0] dev_addr_d;
  logic [7:0] channel_num_q;
  logic [7:0] channel_num_d;
  logic [7:0] if_ctrl_q;
  logic [7:0] if_ctrl_d;
  logic [7:0] ofs_ctrl_q;
  logic [7:0] ofs_ctrl_d;
  logic [5:0] base_frequency_word_hi_q;
  logic [5:0] base_frequency_word_hi_d;
  logic [7:0] base_frequency_word_mid_q;
  logic [7:0] base_frequency_word_mid_d;
  logic [7:0] base_frequency_word_lo_q;
  logic [7:0] base_frequency_word_lo_d;
  logic [7:0] mdm_cfg_q;
  logic [7:0] mdm_cfg_d;
  logic [7:0] sym_mant_q;
  logic [7:0] sym_mant_d;
  logic [7:0] pkt_len_q;
  logic [7:0] pkt_len_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'h0});
  endfunction

  // Next value of one byte register: masked write byte when strobed, else hold
  function automatic logic [7:0] upd(input logic we, input logic [7:0] old,
      input logic [7:0] wbyte, input logic [7:0] mask);
    upd = we ? (wbyte & mask) : old;
  endfunction

  wire logic wr_en = psel && penable && pwrite && pstrb[0];
  wire logic rd_setup = psel && !penable && !pwrite;
  wire logic [7:0] wb = pwdata[7:0];
  wire logic hit_pc = hit(paddr, rpf_pkg::IDX_PKT_CTRL);
  wire logic hit_da = hit(paddr, rpf_pkg::IDX_DEV_ADDR);
  wire logic hit_cn = hit(paddr, rpf_pkg::IDX_CHANNEL_NUM);
  wire logic hit_if = hit(paddr, rpf_pkg::IDX_IF_CTRL);
  wire logic hit_of = hit(paddr, rpf_pkg::IDX_OFS_CTRL);
  wire logic hit_fh = hit(paddr, rpf_pkg::IDX_BASE_FREQUENCY_WORD_HI);
  wire logic hit_fm = hit(paddr, rpf_pkg::IDX_BASE_FREQUENCY_WORD_MID);
  wire logic hit_fl = hit(paddr, rpf_pkg::IDX_BASE_FREQUENCY_WORD_LO);
  wire logic hit_md = hit(paddr, rpf_pkg::IDX_MDM_CFG);
  wire logic hit_sm = hit(paddr, rpf_pkg::IDX_SYM_MANT);
  wire logic hit_pl = hit(paddr, rpf_pkg::IDX_PKT_LEN);
  wire logic hit_any = hit_pc | hit_da | hit_cn | hit_if | hit_of | hit_fh | hit_fm |
                       hit_fl | hit_md | hit_sm | hit_pl;

  // Write strobes, one per register
  wire logic we_pc = wr_en && hit_pc;
  wire logic we_da = wr_en && hit_da;
  wire logic we_cn = wr_en && hit_cn;
  wire logic we_if = wr_en && hit_if;
  wire logic we_of = wr_en && hit_of;
  wire logic we_fh = wr_en && hit_fh;
  wire logic we_fm = wr_en && hit_fm;
  wire logic we_fl = wr_en && hit_fl;
  wire logic we_md = wr_en && hit_md;
  wire logic we_sm = wr_en && hit_sm;
  wire logic we_pl = wr_en && hit_pl;

  // Read-back values; unused bits come back zero
  wire logic [7:0] rb_pc = pkt_ctrl_q & rpf_pkg::PKT_CTRL_MASK;
  wire logic [7:0] rb_da = dev_addr_q;
  wire logic [7:0] rb_cn = channel_num_q;
  wire logic [7:0] rb_if = if_ctrl_q & rpf_pkg::IF_CTRL_MASK;
  wire logic [7:0] rb_of = ofs_ctrl_q;
  wire logic [7:0] rb_fh = {rpf_pkg::BASE_FREQUENCY_WORD_HI_FIXED, base_frequency_word_hi_q};
  wire logic [7:0] rb_fm = base_frequency_word_mid_q;
  wire logic [7:0] rb_fl = base_frequency_word_lo_q;
  wire logic [7:0] rb_md = mdm_cfg_q;
  wire logic [7:0] rb_sm = sym_mant_q;
  wire logic [7:0] rb_pl = pkt_len_q;

  wire logic [7:0] rd_byte =
    hit_pc ? rb_pc :
    hit_da ? rb_da :
    hit_cn ? rb_cn :
    hit_if ? rb_if :
    hit_of ? rb_of :
    hit_fh ? rb_fh :
    hit_fm ? rb_fm :
    hit_fl ? rb_fl :
    hit_md ? rb_md :
    hit_sm ? rb_sm :
    hit_pl ? rb_pl : 8'h00;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_q;

  // Captured in the setup cycle, so read data stands through the whole access phase
  assign prdata_d = rd_setup ? {24'h000000, rd_byte} : prdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Writes are masked on the way in, so unused bits never hold a one
  assign pkt_ctrl_d = upd(we_pc, pkt_ctrl_q, wb, rpf_pkg::PKT_CTRL_MASK);
  assign dev_addr_d = upd(we_da, dev_addr_q, wb, 8'hFF);
  assign channel_num_d = upd(we_cn, channel_num_q, wb, 8'hFF);
  assign if_ctrl_d = upd(we_if, if_ctrl_q, wb, rpf_pkg::IF_CTRL_MASK);
  assign ofs_ctrl_d = upd(we_of, ofs_ctrl_q, wb, 8'hFF);
  assign base_frequency_word_hi_d = 6'(upd(we_fh, {2'h0, base_frequency_word_hi_q}, wb, rpf_pkg::BASE_FREQUENCY_WORD_HI_MASK));
  assign base_frequency_word_mid_d = upd(we_fm, base_frequency_word_mid_q, wb, 8'hFF);
  assign base_frequency_word_lo_d = upd(we_fl, base_frequency_word_lo_q, wb, 8'hFF);
  assign mdm_cfg_d = upd(we_md, mdm_cfg_q, wb, 8'hFF);
  assign sym_mant_d = upd(we_sm, sym_mant_q, wb, 8'hFF);
  assign pkt_len_d = upd(we_pl, pkt_len_q, wb, 8'hFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_ctrl_q <= rpf_pkg::PKT_CTRL_RST;
    end else begin
      pkt_ctrl_q <= pkt_ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_addr_q <= rpf_pkg::DEV_ADDR_RST;
    end else begin
      dev_addr_q <= dev_addr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_num_q <= rpf_pkg::CHANNEL_NUM_RST;
    end else begin
      channel_num_q <= channel_num_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_ctrl_q <= rpf_pkg::IF_CTRL_RST;
    end else begin
      if_ctrl_q <= if_ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ofs_ctrl_q <= rpf_pkg::OFS_CTRL_RST;
    end else begin
      ofs_ctrl_q <= ofs_ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_frequency_word_hi_q <= rpf_pkg::BASE_FREQUENCY_WORD_HI_RST;
    end else begin
      base_frequency_word_hi_q <= base_frequency_word_hi_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_frequency_word_mid_q <= rpf_pkg::BASE_FREQUENCY_WORD_MID_RST;
    end else begin
      base_frequency_word_mid_q <= base_frequency_word_mid_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_frequency_word_lo_q <= rpf_pkg::BASE_FREQUENCY_WORD_LO_RST;
    end else begin
      base_frequency_word_lo_q <= base_frequency_word_lo_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdm_cfg_q <= rpf_pkg::MDM_CFG_RST;
    end else begin
      mdm_cfg_q <= mdm_cfg_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_mant_q <= rpf_pkg::SYM_MANT_RST;
    end else begin
      sym_mant_q <= sym_mant_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_len_q <= rpf_pkg::PKT_LEN_RST;
    end else begin
      pkt_len_q <= pkt_len_d;
    end
  end

  // Packet settings; reserved bit 3 is stored but steers nothing
  wire logic [1:0] fmt_code = pkt_ctrl_q[5:4];
  wire logic [1:0] len_code = pkt_ctrl_q[1:0];
  assign pkt_cfg.whitening_enable = pkt_ctrl_q[6] && !legacy_compat_enable;
  assign legacy_conflict = pkt_ctrl_q[6] && legacy_compat_enable;
  assign pkt_cfg.packet_format_select =
    (fmt_code == rpf_pkg::FMT_NORMAL) ? rpf_pkg::RPF_MODE_NORMAL :
    (fmt_code == rpf_pkg::FMT_PN9_TX) ? rpf_pkg::RPF_MODE_PN9_TX :
    rpf_pkg::RPF_MODE_RESERVED;
  // PN9 applies only to transmit; receive stays normal
  assign pkt_cfg.pn9_tx_active = (fmt_code == rpf_pkg::FMT_PN9_TX);
  assign pkt_cfg.crc_enable = pkt_ctrl_q[2];
  assign pkt_cfg.fixed_length = (len_code == rpf_pkg::LEN_FIXED);
  assign pkt_cfg.variable_length = (len_code == rpf_pkg::LEN_VARIABLE);
  assign pkt_cfg.packet_length_register = pkt_len_q;
  assign pkt_cfg.device_address = dev_addr_q;

  // Address filter: mode 00 none, 01 exact, 10 plus 0x00, 11 plus 0x00 and 0xFF
  wire logic addr_eq = (rx_address == dev_addr_q);
  wire logic is_zero = (rx_address == rpf_pkg::BCAST_ZERO);
  wire logic is_ones = (rx_address == rpf_pkg::BCAST_ONES);
  wire logic filt_off = (rx_addr_check_mode == 2'h0);
  wire logic zero_ok = rx_addr_check_mode[1];
  wire logic ones_ok = (rx_addr_check_mode == 2'h3);
  assign rx_address_match = filt_off || addr_eq || (zero_ok && is_zero) ||
                            (ones_ok && is_ones);

  // Frequency words, in units of reference/2^16
  wire logic [23:0] base_word = {rpf_pkg::BASE_FREQUENCY_WORD_HI_FIXED, base_frequency_word_hi_q, base_frequency_word_mid_q, base_frequency_word_lo_q};
  // Widen before multiplying so the product keeps all sixteen bits
  wire logic [31:0] channel_term = 32'(channel_num_q) * 32'(channel_spacing);
  // Offset step is 4x coarser than the base step; sign-extend then scale
  wire logic [31:0] ofs_term = 32'(signed'({{24{ofs_ctrl_q[7]}}, ofs_ctrl_q}) <<<
                                    (rpf_pkg::BASE_FREQUENCY_WORD_SHIFT - rpf_pkg::OFS_SHIFT));
  // IF step is 64x coarser than the base step
  wire logic [31:0] if_term = 32'({27'h0, if_ctrl_q[4:0]} <<
                                   (rpf_pkg::BASE_FREQUENCY_WORD_SHIFT - rpf_pkg::IF_SHIFT));
  assign base_frequency_word_tx_word = {8'h00, base_word} + channel_term + ofs_term;
  assign base_frequency_word_rx_word = base_frequency_word_tx_word - if_term;

  // Decimation factor (4+M)*2^E; the fixed 8 stays in the filter
  wire logic [2:0] bw_lin = 3'(rpf_pkg::BW_BASE) + {1'b0, mdm_cfg_q[5:4]};
  // Largest factor is 7 times 8, so six bits are needed
  assign decim_ratio = {3'h0, bw_lin} << mdm_cfg_q[7:6];
  // Hidden leading one above the 8 stored mantissa bits
  assign symbol_rate_word = {mdm_cfg_q[3:0], 1'b1, sym_mant_q};

  assign base_frequency_word_cfg.base_frequency_word = base_word;
  assign base_frequency_word_cfg.channel_index = channel_num_q;
  assign base_frequency_word_cfg.intermediate_base_frequency_word_setting = if_ctrl_q[4:0];
  assign base_frequency_word_cfg.synth_offset_value = ofs_ctrl_q;
  assign base_frequency_word_cfg.bandwidth_exponent = mdm_cfg_q[7:6];
  assign base_frequency_word_cfg.bandwidth_mantissa = mdm_cfg_q[5:4];
  assign base_frequency_word_cfg.symbol_rate_exponent = mdm_cfg_q[3:0];
  assign base_frequency_word_cfg.symbol_rate_mantissa = sym_mant_q;
endmodule // rpf_regs
`default_nettype wire

/* include/rpf_pkg.sv */
`default_nettype none
package rpf_pkg;
  // Register indices; the APB byte address is four times the index
  localparam logic [15:0] IDX_PKT_CTRL = 16'hDF04;
  localparam logic [15:0] IDX_DEV_ADDR = 16'hDF05;
  localparam logic [15:0] IDX_CHANNEL_NUM = 16'hDF06;
  localparam logic [15:0] IDX_IF_CTRL = 16'hDF07;
  localparam logic [15:0] IDX_OFS_CTRL = 16'hDF08;
  localparam logic [15:0] IDX_BASE_FREQUENCY_WORD_HI = 16'hDF09;
  localparam logic [15:0] IDX_BASE_FREQUENCY_WORD_MID = 16'hDF0A;
  localparam logic [15:0] IDX_BASE_FREQUENCY_WORD_LO = 16'hDF0B;
  localparam logic [15:0] IDX_MDM_CFG = 16'hDF0C;
  localparam logic [15:0] IDX_SYM_MANT = 16'hDF0D;
  localparam logic [15:0] IDX_PKT_LEN = 16'hDF02;

  // Writable masks; bits outside read zero, except the top two of the base HI byte, which read the fixed 01
  localparam logic [7:0] PKT_CTRL_MASK = 8'h7F;
  localparam logic [7:0] IF_CTRL_MASK = 8'h3F;
  localparam logic [7:0] BASE_FREQUENCY_WORD_HI_MASK = 8'h3F;
  localparam logic [1:0] BASE_FREQUENCY_WORD_HI_FIXED = 2'h1;

  // Reset values
  localparam logic [7:0] PKT_CTRL_RST = 8'h45;
  localparam logic [7:0] DEV_ADDR_RST = 8'h00;
  localparam logic [7:0] CHANNEL_NUM_RST = 8'h00;
  localparam logic [7:0] IF_CTRL_RST = 8'h0F;
  localparam logic [7:0] OFS_CTRL_RST = 8'h00;
  localparam logic [5:0] BASE_FREQUENCY_WORD_HI_RST = 6'h1E;
  localparam logic [7:0] BASE_FREQUENCY_WORD_MID_RST = 8'hC4;
  localparam logic [7:0] BASE_FREQUENCY_WORD_LO_RST = 8'hEC;
  localparam logic [7:0] MDM_CFG_RST = 8'h8C;
  localparam logic [7:0] SYM_MANT_RST = 8'h22;
  localparam logic [7:0] PKT_LEN_RST = 8'hFF;

  // Field codes
  localparam logic [1:0] FMT_NORMAL = 2'h0;
  localparam logic [1:0] FMT_PN9_TX = 2'h2;
  localparam logic [1:0] LEN_FIXED = 2'h0;
  localparam logic [1:0] LEN_VARIABLE = 2'h1;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hFF;
  localparam int IF_SHIFT = 10;
  localparam int OFS_SHIFT = 14;
  localparam int BASE_FREQUENCY_WORD_SHIFT = 16;
  localparam int BW_BASE = 4;

  typedef enum logic [1:0] {
    RPF_MODE_NORMAL,
    RPF_MODE_PN9_TX,
    RPF_MODE_RESERVED
  } rpf_fmt_t;

  typedef struct packed {
    logic whitening_enable;
    rpf_fmt_t packet_format_select;
    logic pn9_tx_active;
    logic crc_enable;
    logic fixed_length;
    logic variable_length;
    logic [7:0] packet_length_register;
    logic [7:0] device_address;
  } rpf_pkt_cfg_t;

  typedef struct packed {
    logic [23:0] base_frequency_word;
    logic [7:0] channel_index;
    logic [4:0] intermediate_base_frequency_word_setting;
    logic [7:0] synth_offset_value;
    logic [1:0] bandwidth_exponent;
    logic [1:0] bandwidth_mantissa;
    logic [3:0] symbol_rate_exponent;
    logic [7:0] symbol_rate_mantissa;
  } rpf_base_frequency_word_cfg_t;
endpackage
`default_nettype wire

/* dv/rpf_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rpf_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] base_frequency_word_rx_word,
  input wire logic [31:0] base_frequency_word_tx_word,
  input wire logic [7:0] channel_spacing,
  input wire logic [5:0] decim_ratio,
  input wire logic [12:0] symbol_rate_word,
  input wire rpf_pkg::rpf_pkt_cfg_t pkt_cfg,
  input wire rpf_pkg::rpf_base_frequency_word_cfg_t base_frequency_word_cfg
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Offset is signed and four times coarser than the base word
  wire [31:0] tx_exp = 32'(base_frequency_word_cfg.base_frequency_word)
    + 32'(base_frequency_word_cfg.channel_index) * 32'(channel_spacing)
    + {{22{base_frequency_word_cfg.synth_offset_value[7]}}, base_frequency_word_cfg.synth_offset_value, 2'h0};
  wire chw = psel && penable && pwrite && pstrb[0]
    && paddr == {14'h0, rpf_pkg::IDX_CHANNEL_NUM, 2'h0};
  wire pcw = psel && penable && pwrite && pstrb[0]
    && paddr == {14'h0, rpf_pkg::IDX_PKT_CTRL, 2'h0};
  property p_pn9;
    pcw |=> pkt_cfg.fixed_length == ($past(pwdata[1:0]) == 2'h0)
      && pkt_cfg.variable_length == ($past(pwdata[1:0]) == 2'h1)
      && pkt_cfg.pn9_tx_active == ($past(pwdata[5:4]) == 2'h2);
  endproperty
  a_pn9: assert property (p_pn9) else $error("length or format decode wrong");
  property p_tx; base_frequency_word_tx_word == tx_exp; endproperty
  a_tx: assert property (p_tx) else $error("tx word wrong");
  property p_rx;
    base_frequency_word_rx_word == base_frequency_word_tx_word - {21'h0, base_frequency_word_cfg.intermediate_base_frequency_word_setting, 6'h0};
  endproperty
  a_rx: assert property (p_rx) else $error("rx word wrong");
  property p_fhi; base_frequency_word_cfg.base_frequency_word[23:22] == 2'h1; endproperty
  a_fhi: assert property (p_fhi) else $error("base top bits wrong");
  property p_dec;
    decim_ratio == 6'((6'h4 + 6'(base_frequency_word_cfg.bandwidth_mantissa)) << base_frequency_word_cfg.bandwidth_exponent);
  endproperty
  a_dec: assert property (p_dec) else $error("decimation wrong");
  property p_sym;
    symbol_rate_word == {base_frequency_word_cfg.symbol_rate_exponent, 1'b1, base_frequency_word_cfg.symbol_rate_mantissa};
  endproperty
  a_sym: assert property (p_sym) else $error("symbol rate wrong");
  property p_chw;
    chw |=> base_frequency_word_cfg.channel_index == 8'($past(pwdata))
      ##1 $stable(base_frequency_word_cfg.channel_index) || chw;
  endproperty
  a_chw: assert property (p_chw) else $error("channel write lost");
  property p_fmt; pkt_cfg.pn9_tx_active |-> pkt_cfg.packet_format_select == rpf_pkg::RPF_MODE_PN9_TX; endproperty
  a_fmt: assert property (p_fmt) else $error("pn9 without its code");
  c_pn9: cover property (pkt_cfg.pn9_tx_active);
  c_neg: cover property (base_frequency_word_cfg.synth_offset_value[7]);
  c_chw: cover property (chw);
endmodule // rpf_chk
bind rpf_regs rpf_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .base_frequency_word_rx_word(base_frequency_word_rx_word),
  .base_frequency_word_tx_word(base_frequency_word_tx_word), .channel_spacing(channel_spacing), .decim_ratio(decim_ratio),
  .symbol_rate_word(symbol_rate_word), .pkt_cfg(pkt_cfg), .base_frequency_word_cfg(base_frequency_word_cfg));
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_address_match, legacy_conflict;
  logic legacy_compat_enable, e;
  logic [31:0] paddr, pwdata, prdata, base_frequency_word_rx_word, base_frequency_word_tx_word;
  logic [3:0] pstrb;
  logic [7:0] rx_address, channel_spacing, r;
  logic [1:0] rx_addr_check_mode;
  logic [5:0] decim_ratio;
  logic [12:0] symbol_rate_word;
  rpf_pkg::rpf_pkt_cfg_t pkt_cfg;
  rpf_pkg::rpf_base_frequency_word_cfg_t base_frequency_word_cfg;
  int fail_count, n_checks, i, k;
  logic [15:0] idx [11] = '{16'hDF04, 16'hDF05, 16'hDF06, 16'hDF07, 16'hDF08, 16'hDF09,
    16'hDF0A, 16'hDF0B, 16'hDF0C, 16'hDF0D, 16'hDF02};
  logic [7:0] rstv [11] = '{8'h45, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h5E, 8'hC4, 8'hEC, 8'h8C,
    8'h22, 8'hFF};
  logic [7:0] mk [11] = '{8'h7F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF};
  logic [7:0] m [11];
  rpf_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_address(rx_address),
    .rx_addr_check_mode(rx_addr_check_mode), .rx_address_match(rx_address_match),
    .legacy_conflict(legacy_conflict), .base_frequency_word_rx_word(base_frequency_word_rx_word),
    .base_frequency_word_tx_word(base_frequency_word_tx_word), .channel_spacing(channel_spacing), .decim_ratio(decim_ratio),
    .symbol_rate_word(symbol_rate_word), .legacy_compat_enable(legacy_compat_enable),
    .pkt_cfg(pkt_cfg), .base_frequency_word_cfg(base_frequency_word_cfg));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
      input logic [3:0] s);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'($urandom), d}; pstrb <= s;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input int j, input logic [7:0] d);
    apb(1'b1, {14'h0, idx[j], 2'h0}, d, 4'hF);
    // Top two base bits are fixed at 01 whatever is written
    m[j] = (d & mk[j]) | (j == 5 ? 8'h40 : 8'h00);
  endtask
  task automatic rd_chk(input int j);
    apb(1'b0, {14'h0, idx[j], 2'h0}, 8'h00, 4'h0);
    `CHK({e, r}, {1'b0, m[j]})
    `CHK(prdata[31:8], 24'h000000)
  endtask
  task automatic out_chk;
    logic [31:0] tx;
    logic [1:0] wl;
    logic [1:0] lc;
    logic am;
    tx = {m[5], m[6], m[7]} + m[2] * channel_spacing + {{22{m[4][7]}}, m[4], 2'h0};
    wl = {2{m[0][6]}} & {~legacy_compat_enable, legacy_compat_enable};
    lc = {m[0][1:0] == 2'h0, m[0][1:0] == 2'h1};
    am = rx_addr_check_mode == 2'h0 || rx_address == m[1] ||
      (rx_addr_check_mode[1] && (rx_address == 8'h00 ||
      (rx_addr_check_mode[0] && rx_address == 8'hFF)));
    `CHK(base_frequency_word_tx_word, tx)
    `CHK(base_frequency_word_rx_word, tx - 32'(m[3][4:0]) * 64)
    `CHK(decim_ratio, 6'((4 + m[8][5:4]) << m[8][7:6]))
    `CHK(symbol_rate_word, {m[8][3:0], 1'b1, m[9]})
    `CHK({pkt_cfg.whitening_enable, legacy_conflict}, wl)
    `CHK(pkt_cfg.pn9_tx_active, m[0][5:4] == 2'h2)
    `CHK(pkt_cfg.crc_enable, m[0][2])
    `CHK({pkt_cfg.fixed_length, pkt_cfg.variable_length}, lc)
    `CHK(pkt_cfg.packet_length_register, m[10])
    `CHK(rx_address_match, am)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h248c0ca9));
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, legacy_compat_enable} = '0;
    {rx_address, rx_addr_check_mode, channel_spacing} = '0;
    m = rstv;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 11; i++) rd_chk(i);
    apb(1'b0, 32'h37C00, 8'h00, 4'hF);
    `CHK({e, r}, 9'h100)
    out_chk();
    $display("test reset done");
    for (k = 0; k < 56; k++) begin
      i = k < 16 ? 0 : $urandom_range(10);
      // Sweep every format and length code, then random registers
      wr(i, k < 16 ? {2'($urandom), 2'(k >> 2), 2'($urandom), 2'(k)} : 8'($urandom));
      rd_chk(i);
      channel_spacing <= 8'($urandom);
      legacy_compat_enable <= 1'($urandom);
      rx_addr_check_mode <= 2'($urandom);
      rx_address <= k % 4 == 0 ? m[1] : k % 4 == 1 ? 8'h00 : k % 4 == 2 ? 8'hFF : 8'($urandom);
      @(posedge pclk);
      out_chk();
    end
    $display("test random done");
    apb(1'b1, {14'h0, idx[1], 2'h0}, ~m[1], 4'hE);
    rd_chk(1);
    $display("test strobe done");
    close_out();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    close_out();
  end
endmodule // tb
`default_nettype wire
